// [verilog/twf_target.sv]
// Behaviour
// - Single memory write posts without stop
// - Pending request starts command/address phase
// - Dual-port flags: dual bit0, burst bit1
// - New address each enabled clock, final marked
// - User pulls data only when present
// - Single dual-port access: final with data
// - Quad-port carries 16-bit pieces, LSB first
// - Quad-port flags: dual bit16, burst bit17
// - Wide base range: two address pieces
// - Quad word takes two halves, final last
// - Full FIFO: disconnect or eight waits
// - Ready asserted together with device select; held off here while the FIFO is full
// - Dual-port data with lane enables on side
// - Burst final only on last item
// - Dual-port count sequence 0,1,4,5
// - Quad-port count sequence 0..3,4..7
// - Address moves only while enabled
// - Data moves with address enable high
// - Final: to 4 after address, 0 after data
// - Idle while no request pending
// - Almost empty at eight double words
// - FIFO clear resets FIFO and count
// - FIFO holds 64 words of 32 bits
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module twf_target #(
  parameter int DEPTH = twf_pkg::FIFO_DEPTH,
  parameter int ALMOST = twf_pkg::ALMOST_WORDS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fabric side
  twf_if.dev link,
  // Configuration
  input wire logic quad_mode,
  input wire logic wide_base,
  input wire logic burst_stall_n,
  // Posted transaction header from the bus side
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic [3:0] hdr_cmd,
  input wire logic [63:0] hdr_addr,
  input wire logic hdr_dual,
  input wire logic hdr_burst,
  // Posted write data from the bus side
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [31:0] wd_data,
  input wire logic [3:0] wd_be,
  input wire logic wd_last,
  // Bus termination hints
  input wire logic devsel_start,
  output logic trdy_n,
  output logic disconnect_req,
  output logic wait_req
);
  localparam int PW = $clog2(DEPTH);
  localparam int EW = twf_pkg::WORD_W + twf_pkg::LANE_W + 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
  localparam logic [PW:0] ALMOST_C = (PW + 1)'(ALMOST);
  localparam logic [3:0] WAITS_C = 4'(twf_pkg::MAX_WAITS);

  typedef enum logic [7:0] {
    S_IDLE = 8'b0000_0001,
    S_A1 = 8'b0000_0010,
    S_A2 = 8'b0000_0100,
    S_A3 = 8'b0000_1000,
    S_D0 = 8'b0001_0000,
    S_D1 = 8'b0010_0000,
    S_D2 = 8'b0100_0000,
    S_D3 = 8'b1000_0000
  } twf_state_t;

  // Clear input acts as a second asynchronous reset
  logic rst_n;
  assign rst_n = presetn & link.fifo_clear_n;

  twf_state_t state_ff, nxt_state;
  logic [EW-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_ff, rd_ptr_ff, count;
  logic [3:0] cmd_ff, wait_cnt_ff;
  logic [63:0] addr_ff;
  logic dual_ff, burst_ff, held_ff, gap_ff;
  logic [EW-1:0] head;
  logic full, push, pop, addr_step, data_step, addr_last, item_final;
  logic in_addr, in_data, second_half;
  logic [1:0] piece;

  // 64 x 32 write data store
  assign count = wr_ptr_ff - rd_ptr_ff;
  assign full = (count == DEPTH_C);
  assign head = mem[rd_ptr_ff[PW-1:0]];
  assign wd_ready = !full;
  assign push = wd_valid && !full;
  assign link.wr_fifo_empty_n = (count != '0);
  assign link.wr_fifo_almost_empty_n = !(count <= ALMOST_C);

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_ff[PW-1:0]] <= {wd_last, wd_be, wd_data};
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  // Full FIFO: stop at once, or stall up to the wait limit
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_ff <= '0;
    end else if (wd_valid && full && !burst_stall_n) begin
      if (wait_cnt_ff != WAITS_C) begin
        wait_cnt_ff <= wait_cnt_ff + 1'b1;
      end
    end else begin
      wait_cnt_ff <= '0;
    end
  end
  assign wait_req = wd_valid && full && !burst_stall_n &&
    (wait_cnt_ff != WAITS_C);
  assign disconnect_req = wd_valid && full &&
    (burst_stall_n || wait_cnt_ff == WAITS_C);
  // Medium decode: ready goes with select unless the FIFO is full; no stop on single memory
  assign trdy_n = !(devsel_start && !full);

  // Header capture and request release gap
  assign hdr_ready = !held_ff && !gap_ff;
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= 1'b0;
      gap_ff <= 1'b0;
      cmd_ff <= '0;
      addr_ff <= '0;
      dual_ff <= 1'b0;
      burst_ff <= 1'b0;
    end else begin
      gap_ff <= 1'b0;
      if (hdr_valid && hdr_ready) begin
        held_ff <= 1'b1;
        cmd_ff <= hdr_cmd;
        addr_ff <= hdr_addr;
        dual_ff <= hdr_dual;
        burst_ff <= hdr_burst;
      end else if (data_step && item_final) begin
        held_ff <= 1'b0;
        gap_ff <= 1'b1;
      end
    end
  end
  assign link.pending_request_n = !held_ff;
  assign link.bus_command_word = cmd_ff;
  assign link.port_quad = quad_mode;

  // Sequencing
  assign in_addr = (state_ff == S_IDLE) || (state_ff == S_A1) ||
    (state_ff == S_A2) || (state_ff == S_A3);
  assign in_data = !in_addr;
  assign addr_step = held_ff && in_addr && !link.addr_phase_en_n;
  assign data_step = held_ff && in_data && link.addr_phase_en_n &&
    !link.wrdata_pull_en_n && link.wr_fifo_empty_n;
  assign second_half = (state_ff == S_D1) || (state_ff == S_D3);
  assign pop = data_step && (!quad_mode || second_half);

  always_comb begin
    case (state_ff)
      S_A1: piece = 2'd1;
      S_A2: piece = 2'd2;
      S_A3: piece = 2'd3;
      default: piece = 2'd0;
    endcase
  end

  // Pieces: dual 1 or 2; quad 1, 2 or 4 by range and width
  always_comb begin
    if (!quad_mode) begin
      addr_last = dual_ff ? (piece == 2'd1) : 1'b1;
    end else if (dual_ff) begin
      addr_last = (piece == 2'd3);
    end else if (wide_base) begin
      addr_last = (piece == 2'd1);
    end else begin
      addr_last = 1'b1;
    end
  end

  // Data final only on the last item or half of a word
  always_comb begin
    if (in_addr) begin
      item_final = addr_last;
    end else begin
      item_final = head[EW-1] && (!quad_mode || second_half);
    end
  end
  assign link.final_item_n = !(held_ff && item_final);

  always_comb begin
    nxt_state = state_ff;
    if (addr_step) begin
      case (state_ff)
        S_IDLE: nxt_state = addr_last ? S_D0 : S_A1;
        S_A1: nxt_state = addr_last ? S_D0 : S_A2;
        S_A2: nxt_state = addr_last ? S_D0 : S_A3;
        default: nxt_state = S_D0;
      endcase
    end else if (data_step) begin
      case (state_ff)
        S_D0: nxt_state = (!quad_mode && item_final) ? S_IDLE : S_D1;
        S_D1: begin
          if (item_final) begin
            nxt_state = S_IDLE;
          end else begin
            nxt_state = quad_mode ? S_D2 : S_D0;
          end
        end
        S_D2: nxt_state = S_D3;
        S_D3: nxt_state = item_final ? S_IDLE : S_D0;
        default: nxt_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    case (state_ff)
      S_A1: link.state_count = twf_pkg::CNT_A1;
      S_A2: link.state_count = twf_pkg::CNT_A2;
      S_A3: link.state_count = twf_pkg::CNT_A3;
      S_D0: link.state_count = twf_pkg::CNT_D0;
      S_D1: link.state_count = twf_pkg::CNT_D1;
      S_D2: link.state_count = twf_pkg::CNT_D2;
      S_D3: link.state_count = twf_pkg::CNT_D3;
      default: link.state_count = twf_pkg::CNT_IDLE;
    endcase
  end

  // Receive buses; contents are don't-care while idle, driven zero
  always_comb begin
    link.dp_rx_bus = '0;
    link.dp_rx_side = '0;
    link.quad_port_rx_bus = '0;
    if (held_ff && in_addr) begin
      link.dp_rx_bus = addr_ff[piece[0]*32 +: 32];
      link.dp_rx_side[twf_pkg::DP_DUAL_BIT] = dual_ff;
      link.dp_rx_side[twf_pkg::DP_BURST_BIT] = burst_ff;
      link.quad_port_rx_bus[twf_pkg::PIECE_W-1:0] =
        addr_ff[piece*twf_pkg::PIECE_W +: twf_pkg::PIECE_W];
      link.quad_port_rx_bus[twf_pkg::QP_DUAL_BIT] = dual_ff;
      link.quad_port_rx_bus[twf_pkg::QP_BURST_BIT] = burst_ff;
    end else if (held_ff) begin
      link.dp_rx_bus = head[twf_pkg::WORD_W-1:0];
      link.dp_rx_side = head[EW-2 -: twf_pkg::LANE_W];
      link.quad_port_rx_bus = second_half ?
        {head[EW-2 -: 2], head[31:16]} :
        {head[EW-4 -: 2], head[15:0]};
    end
  end
endmodule
`default_nettype wire

// [shared/twf_pkg.sv]
package twf_pkg;
  // Write FIFO geometry
  localparam int FIFO_DEPTH = 64;
  localparam int WORD_W = 32;
  localparam int LANE_W = 4;
  localparam int ALMOST_WORDS = 8;
  // Wait states allowed on a full FIFO before disconnecting
  localparam int MAX_WAITS = 8;
  // Dual-port side bits and quad-port flag bits
  localparam int DP_DUAL_BIT = 0;
  localparam int DP_BURST_BIT = 1;
  localparam int QP_DUAL_BIT = 16;
  localparam int QP_BURST_BIT = 17;
  localparam int QP_W = 18;
  localparam int PIECE_W = 16;
  // Numeric state count values
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_A1 = 3'h1;
  localparam logic [2:0] CNT_A2 = 3'h2;
  localparam logic [2:0] CNT_A3 = 3'h3;
  localparam logic [2:0] CNT_D0 = 3'h4;
  localparam logic [2:0] CNT_D1 = 3'h5;
  localparam logic [2:0] CNT_D2 = 3'h6;
  localparam logic [2:0] CNT_D3 = 3'h7;
  // Controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR_LO = 8'h08;
  localparam logic [7:0] REG_ADDR_HI = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_DATA = 8'h14;
  localparam logic [7:0] REG_WORDS = 8'h18;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_PENDING = 1;
  localparam int ST_DONE = 2;
  localparam int ST_CNT_LSB = 4;
endpackage

// [shared/twf_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface twf_if;
  logic pending_request_n;
  logic addr_phase_en_n;
  logic wrdata_pull_en_n;
  logic final_item_n;
  logic [3:0] bus_command_word;
  logic [31:0] dp_rx_bus;
  logic [3:0] dp_rx_side;
  logic [17:0] quad_port_rx_bus;
  logic wr_fifo_empty_n;
  logic wr_fifo_almost_empty_n;
  logic [2:0] state_count;
  logic port_quad;
  logic fifo_clear_n;
  modport dev (
    output pending_request_n, final_item_n, bus_command_word, dp_rx_bus,
    output dp_rx_side, quad_port_rx_bus, wr_fifo_empty_n, state_count,
    output wr_fifo_almost_empty_n, port_quad,
    input addr_phase_en_n, wrdata_pull_en_n, fifo_clear_n
  );
  modport usr (
    input pending_request_n, final_item_n, bus_command_word, dp_rx_bus,
    input dp_rx_side, quad_port_rx_bus, wr_fifo_empty_n, state_count,
    input wr_fifo_almost_empty_n, port_quad,
    output addr_phase_en_n, wrdata_pull_en_n, fifo_clear_n
  );
endinterface
`default_nettype wire

// [verilog/twf_user.sv]
`timescale 1ns/100ps
`default_nettype none
module twf_user (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Target port
  twf_if.usr link,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [3:0] {
    U_IDLE = 4'b0001,
    U_ADDR = 4'b0010,
    U_DATA = 4'b0100,
    U_WAIT = 4'b1000
  } twf_ustate_t;

  twf_ustate_t state_ff, nxt_state;
  logic run_ff, clear_ff, done_ff, half_ff;
  logic [1:0] piece_ff;
  logic [63:0] addr_ff;
  logic [3:0] cmd_ff;
  logic [31:0] data_ff, words_ff, prdata_ff;
  logic addr_go, data_go, setup, wr_en, mapped;

  // Address only while request pending; data only when present
  assign addr_go = (state_ff == U_ADDR) && !link.pending_request_n;
  assign data_go = (state_ff == U_DATA) && link.wr_fifo_empty_n;
  assign link.addr_phase_en_n = !addr_go;
  assign link.wrdata_pull_en_n = !data_go;
  assign link.fifo_clear_n = !clear_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      U_IDLE: begin
        if (run_ff && !link.pending_request_n) begin
          nxt_state = U_ADDR;
        end
      end
      U_ADDR: begin
        if (addr_go && !link.final_item_n) begin
          nxt_state = U_DATA;
        end
      end
      U_DATA: begin
        if (data_go && !link.final_item_n) begin
          nxt_state = U_WAIT;
        end
      end
      U_WAIT: begin
        if (link.pending_request_n) begin
          nxt_state = U_IDLE;
        end
      end
      default: nxt_state = U_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= U_IDLE;
    end else if (clear_ff) begin
      state_ff <= U_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Capture of address pieces and data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      piece_ff <= '0;
      half_ff <= 1'b0;
      addr_ff <= '0;
      cmd_ff <= '0;
      data_ff <= '0;
      words_ff <= '0;
    end else if (state_ff == U_IDLE) begin
      piece_ff <= '0;
      half_ff <= 1'b0;
    end else if (addr_go) begin
      cmd_ff <= link.bus_command_word;
      piece_ff <= piece_ff + 1'b1;
      if (link.port_quad) begin
        addr_ff[piece_ff*twf_pkg::PIECE_W +: twf_pkg::PIECE_W] <=
          link.quad_port_rx_bus[twf_pkg::PIECE_W-1:0];
      end else begin
        addr_ff[piece_ff[0]*32 +: 32] <= link.dp_rx_bus;
      end
      if (piece_ff == 2'd0) begin
        words_ff <= '0;
      end
    end else if (data_go) begin
      if (link.port_quad) begin
        half_ff <= !half_ff;
        data_ff[half_ff*twf_pkg::PIECE_W +: twf_pkg::PIECE_W] <=
          link.quad_port_rx_bus[twf_pkg::PIECE_W-1:0];
        if (half_ff) begin
          words_ff <= words_ff + 1'b1;
        end
      end else begin
        data_ff <= link.dp_rx_bus;
        words_ff <= words_ff + 1'b1;
      end
    end
  end

  // APB: zero-wait, read data registered in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      twf_pkg::REG_CTRL, twf_pkg::REG_STATUS, twf_pkg::REG_ADDR_LO,
      twf_pkg::REG_ADDR_HI, twf_pkg::REG_CMD, twf_pkg::REG_DATA,
      twf_pkg::REG_WORDS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 1'b0;
      clear_ff <= 1'b0;
    end else begin
      // Clear is a one-clock pulse, then released at least one clock
      clear_ff <= wr_en && paddr == twf_pkg::REG_CTRL &&
        pwdata[twf_pkg::CTRL_CLEAR] && !clear_ff;
      if (wr_en && paddr == twf_pkg::REG_CTRL) begin
        run_ff <= pwdata[twf_pkg::CTRL_RUN];
      end
    end
  end

  // Done is sticky; a new completion beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else if (data_go && !link.final_item_n) begin
      done_ff <= 1'b1;
    end else if (wr_en && paddr == twf_pkg::REG_STATUS &&
        pwdata[twf_pkg::ST_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup) begin
      prdata_ff <= '0;
      case (paddr)
        twf_pkg::REG_CTRL: begin
          prdata_ff[twf_pkg::CTRL_RUN] <= run_ff;
        end
        twf_pkg::REG_STATUS: begin
          prdata_ff[twf_pkg::ST_BUSY] <= (state_ff != U_IDLE);
          prdata_ff[twf_pkg::ST_PENDING] <= !link.pending_request_n;
          prdata_ff[twf_pkg::ST_DONE] <= done_ff;
          prdata_ff[twf_pkg::ST_CNT_LSB +: 3] <= link.state_count;
        end
        twf_pkg::REG_ADDR_LO: prdata_ff <= addr_ff[31:0];
        twf_pkg::REG_ADDR_HI: prdata_ff <= addr_ff[63:32];
        twf_pkg::REG_CMD: prdata_ff[3:0] <= cmd_ff;
        twf_pkg::REG_DATA: prdata_ff <= data_ff;
        twf_pkg::REG_WORDS: prdata_ff <= words_ff;
        default: prdata_ff <= '0;
      endcase
    end
  end
  assign prdata = prdata_ff;
endmodule
`default_nettype wire

// [sim/twf_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module twf_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic pending_request_n,
  input wire logic addr_phase_en_n,
  input wire logic wrdata_pull_en_n,
  input wire logic final_item_n,
  input wire logic wr_fifo_empty_n,
  input wire logic wr_fifo_almost_empty_n,
  input wire logic [2:0] state_count,
  input wire logic port_quad,
  input wire logic fifo_clear_n
);
  logic take_a;
  logic take_d;
  assign take_a = !pending_request_n && !addr_phase_en_n && !state_count[2];
  assign take_d = addr_phase_en_n && !wrdata_pull_en_n && wr_fifo_empty_n &&
    state_count[2];
  default clocking cb @(posedge pclk); endclocking
  // Clear is asynchronous, so it aborts attempts like reset does
  default disable iff (!presetn || !fifo_clear_n);
  idle_count_a: assert property (pending_request_n |->
    state_count == twf_pkg::CNT_IDLE) else $error("count not idle");
  addr_end_a: assert property (take_a && !final_item_n |=>
    state_count == twf_pkg::CNT_D0) else $error("address end count");
  data_end_a: assert property (take_d && !final_item_n |=>
    state_count == twf_pkg::CNT_IDLE && pending_request_n)
    else $error("data end release");
  count_hold_a: assert property (!take_a && !take_d |=>
    $stable(state_count)) else $error("count moved without transfer");
  dp_addr_a: assert property (!port_quad && take_a && final_item_n |=>
    state_count == twf_pkg::CNT_A1) else $error("dual address step");
  dp_data_a: assert property (!port_quad && take_d && final_item_n |=>
    state_count == ($past(state_count) == twf_pkg::CNT_D0 ?
    twf_pkg::CNT_D1 : twf_pkg::CNT_D0)) else $error("dual data step");
  qp_step_a: assert property (port_quad && (take_a || take_d) &&
    final_item_n |=> state_count == ($past(state_count) == twf_pkg::CNT_D3 ?
    twf_pkg::CNT_D0 : $past(state_count) + 3'h1)) else $error("quad step");
  qp_half_a: assert property (port_quad && take_d && !state_count[0]
    |-> final_item_n) else $error("final on first half");
  pull_guard_a: assert property (!wrdata_pull_en_n |->
    addr_phase_en_n && wr_fifo_empty_n) else $error("pull while empty");
  addr_guard_a: assert property (!addr_phase_en_n |->
    !pending_request_n) else $error("address enable without request");
  empty_pair_a: assert property (!wr_fifo_empty_n |->
    !wr_fifo_almost_empty_n) else $error("empty but not almost empty");
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); fails++; end end
`define WAIT_HI(sig) begin n = 0; do begin @(posedge pclk); n++; end \
  while ((sig) !== 1'h1 && n < 400); if (n >= 400) begin fails++; \
  print_verdict; end end
module testbench;
  logic pclk = 0, presetn = 0, quad_mode = 0, wide_base = 0;
  logic burst_stall_n = 1, hdr_valid = 0, hdr_dual = 0, hdr_burst = 0;
  logic [3:0] hdr_cmd = 0, wd_be = 0;
  logic [63:0] hdr_addr = 0;
  logic wd_valid = 0, wd_last = 0, devsel_start = 0;
  logic [31:0] wd_data = 0, pwdata = 0, prdata, r;
  logic hdr_ready, wd_ready, trdy_n, disconnect_req, wait_req;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
  logic [7:0] paddr = 0;
  int fails = 0, samples_checked = 0, n;
  twf_if link();
  twf_target i_twf_target (.pclk(pclk), .presetn(presetn), .link(link),
    .quad_mode(quad_mode), .wide_base(wide_base),
    .burst_stall_n(burst_stall_n), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr_cmd(hdr_cmd), .hdr_addr(hdr_addr),
    .hdr_dual(hdr_dual), .hdr_burst(hdr_burst), .wd_valid(wd_valid),
    .wd_ready(wd_ready), .wd_data(wd_data), .wd_be(wd_be),
    .wd_last(wd_last), .devsel_start(devsel_start), .trdy_n(trdy_n),
    .disconnect_req(disconnect_req), .wait_req(wait_req));
  twf_user i_twf_user (.pclk(pclk), .presetn(presetn), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  twf_chk i_twf_chk (.pclk(pclk), .presetn(presetn),
    .pending_request_n(link.pending_request_n),
    .addr_phase_en_n(link.addr_phase_en_n),
    .wrdata_pull_en_n(link.wrdata_pull_en_n),
    .final_item_n(link.final_item_n), .wr_fifo_empty_n(link.wr_fifo_empty_n),
    .wr_fifo_almost_empty_n(link.wr_fifo_almost_empty_n),
    .state_count(link.state_count), .port_quad(link.port_quad),
    .fifo_clear_n(link.fifo_clear_n));
  always #12.5 pclk = ~pclk;
  logic [1:0] seen_flags = 0;
  logic [3:0] seen_lanes = 0;
  // Flags of the last address item, lanes of the last data word taken
  always @(posedge pclk) begin
    if (!link.addr_phase_en_n) begin
      seen_flags <= link.port_quad ?
        link.quad_port_rx_bus[twf_pkg::QP_BURST_BIT -: 2] :
        link.dp_rx_side[twf_pkg::DP_BURST_BIT -: 2];
    end
    if (!link.wrdata_pull_en_n) begin
      // Quad halves arrive low pair first, so shift pairs in from the top
      seen_lanes <= link.port_quad ?
        {link.quad_port_rx_bus[twf_pkg::QP_BURST_BIT -: 2],
        seen_lanes[3:2]} :
        link.dp_rx_side;
    end
  end
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    `WAIT_HI(pready)
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic post(input logic [3:0] c, input logic [63:0] a,
      input logic du, input logic bu, input int nw, input logic [31:0] b);
    int n;
    @(posedge pclk);
    hdr_valid <= 1'h1;
    hdr_cmd <= c;
    hdr_addr <= a;
    hdr_dual <= du;
    hdr_burst <= bu;
    `WAIT_HI(hdr_ready)
    hdr_valid <= 1'h0;
    for (int i = 0; i < nw; i++) begin
      wd_valid <= 1'h1;
      wd_data <= b + 32'(i);
      wd_be <= 4'hF ^ 4'(i);
      wd_last <= (i == nw - 1);
      `WAIT_HI(wd_ready)
    end
    wd_valid <= 1'h0;
  endtask
  // One posted write carried across the link and read back by software
  task automatic xfer(input logic q, input logic w, input logic [3:0] c,
      input logic [63:0] a, input logic du, input logic bu, input int nw);
    logic [31:0] b;
    int k;
    b = 32'h5A00_0000 + 32'(nw);
    quad_mode <= q;
    wide_base <= w;
    post(c, a, du, bu, nw, b);
    k = 0;
    do begin
      apb(1'h0, twf_pkg::REG_STATUS, 32'h0000_0000, r);
      k++;
    // Done rises one cycle before the user side drops busy
    end while ((r[2] !== 1'h1 || r[0] !== 1'h0) && k < 100);
    `CHK(r, 32'h0000_0004)
    if (k >= 100) begin
      fails++;
      print_verdict;
    end
    apb(1'h0, twf_pkg::REG_ADDR_LO, 32'h0000_0000, r);
    `CHK(r, a[31:0])
    if (du) begin
      apb(1'h0, twf_pkg::REG_ADDR_HI, 32'h0000_0000, r);
      `CHK(r, a[63:32])
    end
    apb(1'h0, twf_pkg::REG_CMD, 32'h0000_0000, r);
    `CHK(r, {28'h000_0000, c})
    apb(1'h0, twf_pkg::REG_DATA, 32'h0000_0000, r);
    `CHK(r, b + 32'(nw - 1))
    `CHK(seen_flags, {bu, du})
    `CHK(seen_lanes, 4'hF ^ 4'(nw - 1))
    apb(1'h0, twf_pkg::REG_WORDS, 32'h0000_0000, r);
    `CHK(r, 32'(nw))
    apb(1'h1, twf_pkg::REG_STATUS, 32'h0000_0004, r);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, twf_pkg::REG_STATUS, 32'h0000_0000, r);
    `CHK(r, 32'h0000_0000)
    apb(1'h0, 8'h1C, 32'h0000_0000, r);
    `CHK(perr, 1'h1)
    apb(1'h1, twf_pkg::REG_CTRL, 32'h0000_0001, r);
    xfer(1'h0, 1'h0, 4'h7, 64'h0000_0000_1234_5678, 1'h0, 1'h0, 1);
    xfer(1'h0, 1'h0, 4'h7, 64'hDEAD_BEEF_0000_1000, 1'h1, 1'h1, 4);
    xfer(1'h1, 1'h1, 4'h6, 64'h0000_0000_8765_4321, 1'h0, 1'h0, 1);
    xfer(1'h1, 1'h0, 4'h7, 64'h1111_2222_3333_4444, 1'h1, 1'h1, 3);
    // Stop the user side so the FIFO can only fill
    apb(1'h1, twf_pkg::REG_CTRL, 32'h0000_0000, r);
    quad_mode <= 1'h0;
    devsel_start <= 1'h1;
    post(4'h7, 64'h0000_0000_0000_0040, 1'h0, 1'h1, 64, 32'h0000_0000);
    `CHK(link.wr_fifo_almost_empty_n, 1'h1)
    @(posedge pclk);
    wd_valid <= 1'h1;
    @(posedge pclk);
    #1;
    `CHK(wd_ready, 1'h0)
    `CHK(trdy_n, 1'h1)
    `CHK(disconnect_req, 1'h1)
    `CHK(wait_req, 1'h0)
    @(posedge pclk);
    burst_stall_n <= 1'h0;
    wd_valid <= 1'h0;
    @(posedge pclk);
    wd_valid <= 1'h1;
    n = 0;
    repeat (12) begin
      #1;
      n += int'(wait_req);
      @(posedge pclk);
    end
    `CHK(n, 8)
    `CHK(disconnect_req, 1'h1)
    wd_valid <= 1'h0;
    apb(1'h1, twf_pkg::REG_CTRL, 32'h0000_0002, r);
    @(posedge pclk);
    #1;
    `CHK(link.wr_fifo_empty_n, 1'h0)
    `CHK(link.pending_request_n, 1'h1)
    `CHK(link.state_count, twf_pkg::CNT_IDLE)
    `CHK(trdy_n, 1'h0)
    apb(1'h1, twf_pkg::REG_CTRL, 32'h0000_0001, r);
    xfer(1'h0, 1'h0, 4'h3, 64'h0000_0000_0000_2000, 1'h0, 1'h1, 2);
    print_verdict;
  end
endmodule
`default_nettype wire
